// File: verilog/motor_inhibit_consts.svh
// Constants for the motor start inhibit block: timing, limits, offsets, fields
`ifndef MOTOR_INHIBIT_CONSTS_SVH
`define MOTOR_INHIBIT_CONSTS_SVH
`define CLK_PERIOD_NS   10
`define SECOND_NS       1000000000
`define SPH_HOUR_S      12'd3600
`define SPH_MAX_STARTS  3'd5
`define TBS_MAX_MIN     9'd500
`define SEC_PER_MIN     15'd60
`define RB_MAX_S        16'd50000
`define BSP_FMAX        10'd999
`define POLES_MIN       5'd2
`define POLES_MAX       5'd16
`define PRED_MAX_S      10'h3ff
`define ADDR_STARTS_CFG 4'h0
`define ADDR_RB_CFG     4'h1
`define ADDR_RELAY_CFG  4'h2
`define ADDR_BSP_CFG    4'h3
`define ADDR_COMMAND    4'h4
`define ADDR_STATUS     4'h5
`define ADDR_LOCKOUT    4'h6
`define ADDR_SPH_LOCK   4'h7
`define F_SPH_LSB       0
`define F_TBS_LSB       16
`define F_BLK_REL_LSB   0
`define F_BSP_REL_LSB   4
`define F_BSP_EN        0
`define F_BSP_PRED      1
`define F_POLES_LSB     4
`define F_FMIN_LSB      16
`define F_EMERG         0
`define F_SWB           4
`define RST_POLES       5'd2
`endif

// File: verilog/motor_inhibit_pkg.sv
// Types shared by the motor start inhibit block
package motor_inhibit_pkg;
	typedef struct packed {
		logic backspin;
		logic restart_block;
		logic between_starts;
		logic starts_per_hour;
	} inhibit_flags_t;
	typedef struct packed {
		logic trip;
		logic spare_output_relay_a;
		logic spare_output_relay_b;
	} relay_set_t;
	typedef enum logic [2:0] {
		BSP_IDLE  = 3'b001,
		BSP_SPIN  = 3'b010,
		BSP_COAST = 3'b100
	} bsp_state_t;
endpackage

// File: verilog/motor_start_inhibit_logic.sv
// Start detection, lockout timers, backspin inhibit and block relay drive
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "motor_inhibit_consts.svh"
module motor_start_inhibit_logic #(
	parameter int SPH_SLOTS   = 5,
	parameter int TICK_CYCLES = `SECOND_NS / `CLK_PERIOD_NS
) (
	input  wire logic                              ref_clk_i,
	input  wire logic                              rstn_i,
	input  wire logic                              motor_current_pin_i,
	input  wire logic                              control_power_pin_i,
	input  wire logic [9:0]                        backspin_sense_input_freq_i,
	input  wire logic                              backspin_sense_input_valid_i,
	input  wire logic [3:0]                        addr_i,
	input  wire logic [31:0]                       wdata_i,
	input  wire logic                              wr_i,
	input  wire logic                              rd_i,
	output logic [31:0]                            rdata_o,
	output motor_inhibit_pkg::relay_set_t          relay_o,
	output motor_inhibit_pkg::inhibit_flags_t      inhibit_o,
	output logic                                   start_blocked_o
);
	import motor_inhibit_pkg::*;

	localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam int SW = $clog2(SPH_SLOTS + 1);

	logic [1:0]  cur_sync_q, pwr_sync_q;
	logic        running_q, start_ev, stop_ev, power_ok;
	logic [TW-1:0] tick_cnt_q;
	logic        tick_q;
	logic [2:0]  cfg_sph_q, cfg_blk_rel_q, cfg_bsp_rel_q;
	logic [8:0]  cfg_tbs_q;
	logic [15:0] cfg_rb_q;
	logic        cfg_bsp_en_q, cfg_pred_en_q;
	logic [4:0]  cfg_poles_q;
	logic [9:0]  cfg_fmin_q;
	logic        emerg;
	logic [11:0] slot_q [SPH_SLOTS];
	logic [SW-1:0] sph_cnt;
	logic [$clog2(SPH_SLOTS)-1:0] load_idx, old_idx;
	logic        have_free;
	logic [11:0] sph_lock;
	logic [14:0] tbs_q;
	logic [15:0] rb_q;
	inhibit_flags_t inh_q;
	logic        any_inh, swb_q;
	bsp_state_t  bsp_q;
	logic [9:0]  prev_f_q, div_by_q, pred_q, quo_q, dvd_q, quo_n;
	logic [10:0] rem_q, rem_n;
	logic [3:0]  div_cnt_q;

	// Synchronizers on the pin inputs
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cur_sync_q <= 2'h0;
			pwr_sync_q <= 2'h0;
		end else begin
			cur_sync_q <= {cur_sync_q[0], motor_current_pin_i};
			pwr_sync_q <= {pwr_sync_q[0], control_power_pin_i};
		end
	end
	assign power_ok = pwr_sync_q[1];

	// Running state and start / stop edges
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			running_q <= 1'b0;
		end else begin
			running_q <= cur_sync_q[1];
		end
	end
	assign start_ev = cur_sync_q[1] & ~running_q;
	assign stop_ev  = ~cur_sync_q[1] & running_q;

	// One-second tick, free running whatever the control power
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + TW'(1);
			tick_q     <= 1'b0;
		end
	end

	// Configuration writes, clamped to their legal ranges; an illegal pole count is ignored
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_sph_q     <= 3'h0;
			cfg_tbs_q     <= 9'h0;
			cfg_rb_q      <= 16'h0;
			cfg_blk_rel_q <= 3'h0;
			cfg_bsp_rel_q <= 3'h0;
			cfg_bsp_en_q  <= 1'b0;
			cfg_pred_en_q <= 1'b0;
			cfg_poles_q   <= `RST_POLES;
			cfg_fmin_q    <= 10'h0;
		end else if (wr_i) begin
			unique case (addr_i)
				`ADDR_STARTS_CFG: begin
					cfg_sph_q <= (wdata_i[`F_SPH_LSB +: 3] > `SPH_MAX_STARTS) ?
						`SPH_MAX_STARTS : wdata_i[`F_SPH_LSB +: 3];
					cfg_tbs_q <= (wdata_i[`F_TBS_LSB +: 9] > `TBS_MAX_MIN) ?
						`TBS_MAX_MIN : wdata_i[`F_TBS_LSB +: 9];
				end
				`ADDR_RB_CFG: begin
					cfg_rb_q <= (wdata_i[15:0] > `RB_MAX_S) ? `RB_MAX_S : wdata_i[15:0];
				end
				`ADDR_RELAY_CFG: begin
					cfg_blk_rel_q <= wdata_i[`F_BLK_REL_LSB +: 3];
					cfg_bsp_rel_q <= wdata_i[`F_BSP_REL_LSB +: 3];
				end
				`ADDR_BSP_CFG: begin
					cfg_bsp_en_q  <= wdata_i[`F_BSP_EN];
					cfg_pred_en_q <= wdata_i[`F_BSP_PRED];
					if (wdata_i[`F_POLES_LSB +: 5] >= `POLES_MIN && wdata_i[`F_POLES_LSB +: 5] <= `POLES_MAX
						&& !wdata_i[`F_POLES_LSB]) begin
						cfg_poles_q <= wdata_i[`F_POLES_LSB +: 5];
					end
					cfg_fmin_q <= (wdata_i[`F_FMIN_LSB +: 10] > `BSP_FMAX) ?
						`BSP_FMAX : wdata_i[`F_FMIN_LSB +: 10];
				end
				default: begin
				end
			endcase
		end
	end
	assign emerg = wr_i && (addr_i == `ADDR_COMMAND) && wdata_i[`F_EMERG];

	// Hourly slot scan: count, free slot, oldest slot, lockout
	always_comb begin
		sph_cnt   = '0;
		load_idx  = '0;
		old_idx   = '0;
		have_free = 1'b0;
		sph_lock  = `SPH_HOUR_S;
		for (int i = 0; i < SPH_SLOTS; i++) begin
			if (slot_q[i] != 12'h0) begin
				sph_cnt = sph_cnt + SW'(1);
				if (slot_q[i] <= sph_lock) begin
					sph_lock = slot_q[i];
					old_idx  = ($clog2(SPH_SLOTS))'(i);
				end
			end else if (!have_free) begin
				have_free = 1'b1;
				load_idx  = ($clog2(SPH_SLOTS))'(i);
			end
		end
		if (sph_cnt == '0) begin
			sph_lock = 12'h0;
		end
		if (!have_free) begin
			load_idx = old_idx;
		end
	end

	// Hourly start slots, one countdown each
	for (genvar g = 0; g < SPH_SLOTS; g++) begin : g_slot
		always_ff @(posedge ref_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				slot_q[g] <= 12'h0;
			end else if (start_ev && cfg_sph_q != 3'h0 && load_idx == g) begin
				slot_q[g] <= `SPH_HOUR_S;
			end else if (emerg && sph_cnt != '0 && old_idx == g) begin
				slot_q[g] <= 12'h0;
			end else if (tick_q && slot_q[g] != 12'h0) begin
				slot_q[g] <= slot_q[g] - 12'h1;
			end
		end
	end

	// Between-starts and restart block countdowns
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tbs_q <= 15'h0;
			rb_q  <= 16'h0;
		end else begin
			if (start_ev) begin
				tbs_q <= 15'(cfg_tbs_q * `SEC_PER_MIN);
			end else if (tick_q && tbs_q != 15'h0) begin
				tbs_q <= tbs_q - 15'h1;
			end
			if (stop_ev) begin
				rb_q <= cfg_rb_q;
			end else if (start_ev) begin
				rb_q <= 16'h0;
			end else if (tick_q && rb_q != 16'h0) begin
				rb_q <= rb_q - 16'h1;
			end
		end
	end

	// Inhibit flags, held until their lockout runs out
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			inh_q.starts_per_hour <= 1'b0;
			inh_q.between_starts  <= 1'b0;
			inh_q.restart_block   <= 1'b0;
		end else begin
			if (stop_ev && cfg_sph_q != 3'h0 && sph_cnt >= SW'(cfg_sph_q)) begin
				inh_q.starts_per_hour <= 1'b1;
			end else if (cfg_sph_q == 3'h0 || sph_cnt < SW'(cfg_sph_q)) begin
				inh_q.starts_per_hour <= 1'b0;
			end
			if (stop_ev && tbs_q != 15'h0) begin
				inh_q.between_starts <= 1'b1;
			end else if (tbs_q == 15'h0) begin
				inh_q.between_starts <= 1'b0;
			end
			inh_q.restart_block <= (rb_q != 16'h0) && !running_q;
		end
	end
	assign any_inh = inh_q.starts_per_hour | inh_q.between_starts | inh_q.restart_block | inh_q.backspin;

	// Start-while-blocked: sticky bit and one-cycle pulse, set wins over clear
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			swb_q           <= 1'b0;
			start_blocked_o <= 1'b0;
		end else begin
			start_blocked_o <= start_ev && any_inh;
			if (start_ev && any_inh) begin
				swb_q <= 1'b1;
			end else if (wr_i && addr_i == `ADDR_STATUS && wdata_i[`F_SWB]) begin
				swb_q <= 1'b0;
			end
		end
	end

	// Backspin state machine
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bsp_q          <= BSP_IDLE;
			inh_q.backspin <= 1'b0;
		end else if (start_ev || !cfg_bsp_en_q) begin
			bsp_q          <= BSP_IDLE;
			inh_q.backspin <= 1'b0;
		end else begin
			unique case (bsp_q)
				BSP_IDLE: begin
					if (stop_ev) begin
						bsp_q          <= BSP_SPIN;
						inh_q.backspin <= 1'b1;
					end
				end
				BSP_SPIN: begin
					if (backspin_sense_input_valid_i && backspin_sense_input_freq_i < cfg_fmin_q) begin
						bsp_q          <= BSP_IDLE;
						inh_q.backspin <= 1'b0;
					end else if (!backspin_sense_input_valid_i && cfg_pred_en_q) begin
						bsp_q <= BSP_COAST;
					end
				end
				BSP_COAST: begin
					if (backspin_sense_input_valid_i) begin
						bsp_q <= BSP_SPIN;
					end else if (pred_q == 10'h0) begin
						bsp_q          <= BSP_IDLE;
						inh_q.backspin <= 1'b0;
					end
				end
			endcase
		end
	end

	// Prediction: per-second drop, serial divide, countdown once signal is lost
	assign rem_n = {rem_q[9:0], dvd_q[9]};
	assign quo_n = {quo_q[8:0], rem_n >= {1'b0, div_by_q}};
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prev_f_q  <= 10'h0;
			div_by_q  <= 10'h0;
			dvd_q     <= 10'h0;
			rem_q     <= 11'h0;
			quo_q     <= 10'h0;
			div_cnt_q <= 4'h0;
			pred_q    <= 10'h0;
		end else if (bsp_q == BSP_SPIN && tick_q && backspin_sense_input_valid_i) begin
			prev_f_q  <= backspin_sense_input_freq_i;
			div_by_q  <= (prev_f_q > backspin_sense_input_freq_i) ?
				prev_f_q - backspin_sense_input_freq_i : 10'h0;
			dvd_q     <= (backspin_sense_input_freq_i > cfg_fmin_q) ?
				backspin_sense_input_freq_i - cfg_fmin_q : 10'h0;
			rem_q     <= 11'h0;
			quo_q     <= 10'h0;
			div_cnt_q <= 4'ha;
			// A tick may land on the last step when ticks are ten cycles apart
			if (div_cnt_q == 4'h1) begin
				pred_q <= (div_by_q == 10'h0) ? `PRED_MAX_S : quo_n;
			end
		end else if (div_cnt_q != 4'h0) begin
			dvd_q     <= {dvd_q[8:0], 1'b0};
			div_cnt_q <= div_cnt_q - 4'h1;
			if (rem_n >= {1'b0, div_by_q}) begin
				rem_q <= rem_n - {1'b0, div_by_q};
				quo_q <= {quo_q[8:0], 1'b1};
			end else begin
				rem_q <= rem_n;
				quo_q <= {quo_q[8:0], 1'b0};
			end
			if (div_cnt_q == 4'h1) begin
				pred_q <= (div_by_q == 10'h0) ? `PRED_MAX_S : quo_n;
			end
		end else if (bsp_q == BSP_COAST && tick_q && pred_q != 10'h0) begin
			pred_q <= pred_q - 10'h1;
		end else if (bsp_q == BSP_IDLE) begin
			prev_f_q <= 10'h0;
			pred_q   <= 10'h0;
		end
	end

	// Relay drive and inhibit outputs, suppressed while control power is off
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			relay_o   <= '0;
			inhibit_o <= '0;
		end else begin
			inhibit_o <= power_ok ? inh_q : '0;
			relay_o   <= (power_ok && !running_q) ?
				relay_set_t'(({3{inh_q.starts_per_hour | inh_q.between_starts | inh_q.restart_block}}
				& cfg_blk_rel_q) | ({3{inh_q.backspin}} & cfg_bsp_rel_q)) : '0;
		end
	end

	// Register read, data one cycle after the strobe
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 32'h0;
		end else if (rd_i) begin
			unique case (addr_i)
				`ADDR_STARTS_CFG: rdata_o <= {7'h0, cfg_tbs_q, 13'h0, cfg_sph_q};
				`ADDR_RB_CFG:     rdata_o <= {16'h0, cfg_rb_q};
				`ADDR_RELAY_CFG:  rdata_o <= {25'h0, cfg_bsp_rel_q, 1'b0, cfg_blk_rel_q};
				`ADDR_BSP_CFG:    rdata_o <= {6'h0, cfg_fmin_q, 7'h0, cfg_poles_q, 2'h0, cfg_pred_en_q, cfg_bsp_en_q};
				`ADDR_STATUS:     rdata_o <= {10'h0, pred_q, 3'(sph_cnt), bsp_q, running_q, swb_q, inh_q};
				`ADDR_LOCKOUT:    rdata_o <= {1'b0, tbs_q, rb_q};
				`ADDR_SPH_LOCK:   rdata_o <= {20'h0, sph_lock};
				default:          rdata_o <= 32'h0;
			endcase
		end else begin
			rdata_o <= 32'h0;
		end
	end

	// Checks
	chk_tbs_load: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		start_ev |=> tbs_q == 15'($past(cfg_tbs_q) * `SEC_PER_MIN)) else $error("tbs not loaded");
	chk_tbs_inhibit: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		stop_ev && tbs_q > 15'h1 |=> inh_q.between_starts) else $error("tbs inhibit missing");
	chk_sph_full: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		stop_ev && cfg_sph_q != 3'h0 && sph_cnt >= SW'(cfg_sph_q) && !emerg |=> inh_q.starts_per_hour)
		else $error("hourly inhibit missing");
	chk_emerg_drop: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		emerg && !start_ev && sph_cnt != '0 |=> sph_cnt == $past(sph_cnt) - SW'(1)) else $error("oldest not dropped");
	chk_rb_load: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		stop_ev |=> rb_q == $past(cfg_rb_q) ##1 (inh_q.restart_block || rb_q == 16'h0))
		else $error("restart block not started");
	chk_relay_run: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		running_q |=> relay_o == '0) else $error("relay on while running");
	chk_relay_free: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!any_inh |=> relay_o == '0) else $error("relay held without inhibit");
	chk_swb_event: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		start_ev && any_inh |=> swb_q && start_blocked_o ##1 !start_blocked_o) else $error("blocked start lost");
	chk_bsp_enter: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		stop_ev && cfg_bsp_en_q && bsp_q == BSP_IDLE |=> bsp_q == BSP_SPIN && inh_q.backspin)
		else $error("backspin not entered");
	chk_bsp_release: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		bsp_q == BSP_SPIN && cfg_bsp_en_q && !start_ev && backspin_sense_input_valid_i
		&& backspin_sense_input_freq_i < cfg_fmin_q |=> !inh_q.backspin) else $error("backspin not released");
	chk_count_nopower: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!power_ok && tick_q && rb_q > 16'h1 && !stop_ev && !start_ev |=> rb_q == $past(rb_q) - 16'h1)
		else $error("timer stalled without power");
	cov_blocked_start: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) start_ev && any_inh);
	cov_sph_inhibit: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) $rose(inh_q.starts_per_hour));
	cov_bsp_coast: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) bsp_q == BSP_COAST ##1 bsp_q == BSP_IDLE);
	cov_emerg: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) emerg && sph_cnt != '0);
endmodule

// File: test/motor_side_model.sv
// Motor current, backspin sense source and relay contacts facing the block
`timescale 1ns/1ps
module motor_side_model (
	input  wire logic       clk_i,
	input  wire logic       run_i,
	input  wire logic       spin_i,
	input  wire logic       lost_i,
	input  wire logic [2:0] relay_i,
	output logic            current_o,
	output logic [9:0]      freq_o,
	output logic            valid_o,
	output logic [2:0]      contact_o
);
	logic [9:0] f_q;
	logic [3:0] cnt_q;
	logic       spin_q;
	// Current follows the run command
	assign current_o = run_i;
	// Contacts follow the coils
	assign contact_o = relay_i;
	// Rotor coasts down five steps every ten clocks once spinning backwards
	always @(posedge clk_i) begin
		spin_q <= spin_i;
		cnt_q  <= (cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1;
		if (spin_i && !spin_q) begin
			f_q <= 10'h12c;
		end else if (cnt_q == 4'h9 && f_q > 10'h004) begin
			f_q <= f_q - 10'h005;
		end
	end
	// A lost or idle sense line shows a toggling pattern, not the last value
	always @(posedge clk_i) begin
		valid_o <= spin_i && !lost_i;
		freq_o  <= (spin_i && !lost_i) ? f_q : ~freq_o;
	end
	initial freq_o = 10'h000;
	initial cnt_q = 4'h0;
endmodule

// File: test/motor_start_inhibit_logic_tb.sv
// Register-driven bench for the start inhibit block
`timescale 1ns/1ps
module motor_start_inhibit_logic_tb;
	import motor_inhibit_pkg::*;
	logic                 ref_clk_i, rstn_i, pwr, run, spin, lost, wr_i, rd_i, cur, bvalid;
	logic [9:0]           bfreq;
	logic [3:0]           addr_i;
	logic [31:0]          wdata_i, rdata_o, v;
	relay_set_t           relay_o;
	inhibit_flags_t       inhibit_o;
	logic                 start_blocked_o;
	logic [4:0]           watch;
	int                   failures, checked;
	assign watch = {start_blocked_o, inhibit_o};
	motor_side_model i_model (.clk_i(ref_clk_i), .run_i(run), .spin_i(spin), .lost_i(lost),
		.relay_i(relay_o), .current_o(cur), .freq_o(bfreq), .valid_o(bvalid), .contact_o());
	motor_start_inhibit_logic #(.SPH_SLOTS(5), .TICK_CYCLES(10)) i_dut (.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i), .motor_current_pin_i(cur), .control_power_pin_i(pwr),
		.backspin_sense_input_freq_i(bfreq), .backspin_sense_input_valid_i(bvalid), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .relay_o(relay_o),
		.inhibit_o(inhibit_o), .start_blocked_o(start_blocked_o));
	// Clock
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task automatic finish_test;
		if (failures == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	task automatic wait_bit(input int b, input logic val, input int lim);
		int n;
		n = 0;
		@(negedge ref_clk_i);
		while (watch[b] !== val && n < lim) begin
			@(negedge ref_clk_i);
			n++;
		end
		if (watch[b] !== val) begin
			check(watch[b], val);
			finish_test;
		end
	endtask
	task automatic pulse_run;
		@(posedge ref_clk_i);
		run <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		run <= 1'b0;
	endtask
	// Main sequence
	initial begin
		failures = 0;
		checked = 0;
		{rstn_i, run, spin, lost, wr_i, rd_i} = 6'h00;
		pwr = 1'b1;
		addr_i = 4'h0;
		wdata_i = 32'h0;
		repeat (2) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		rd(4'h5, v); check(v, 32'h0000_0040);
		rd(4'h8, v); check(v, 32'h0);
		wr(4'h0, 32'h01fe_0007);
		rd(4'h0, v); check(v, 32'h01f4_0005);
		wr(4'h1, 32'h0000_ea60);
		rd(4'h1, v); check(v, 32'h0000_c350);
		// Restart block, start while blocked, self release
		wr(4'h0, 32'h0);
		wr(4'h1, 32'h3);
		wr(4'h2, 32'h0000_0014);
		pulse_run;
		wait_bit(2, 1'b1, 10);
		repeat (2) @(negedge ref_clk_i);
		check(relay_o, 32'h4);
		rd(4'h6, v); check(v[15:0] inside {16'h2, 16'h3}, 32'h1);
		@(posedge ref_clk_i);
		run <= 1'b1;
		wait_bit(4, 1'b1, 10);
		repeat (3) @(negedge ref_clk_i);
		check(relay_o, 32'h0);
		rd(4'h5, v); check(v[5:4], 32'h3);
		wr(4'h5, 32'h10);
		rd(4'h5, v); check(v[4], 32'h0);
		@(posedge ref_clk_i);
		run <= 1'b0;
		wait_bit(2, 1'b1, 10);
		wait_bit(2, 1'b0, 45);
		repeat (2) @(negedge ref_clk_i);
		check(relay_o, 32'h0);
		// Power loss keeps counting; inhibit returns with power
		wr(4'h1, 32'd20);
		pulse_run;
		wait_bit(2, 1'b1, 10);
		@(posedge ref_clk_i);
		pwr <= 1'b0;
		repeat (5) @(negedge ref_clk_i);
		check({inhibit_o, relay_o}, 32'h0);
		repeat (95) @(posedge ref_clk_i);
		pwr <= 1'b1;
		repeat (5) @(negedge ref_clk_i);
		check(inhibit_o, 32'h4);
		wait_bit(2, 1'b0, 120);
		// Starts per hour, every attempt counted, emergency restart
		wr(4'h1, 32'h0);
		wr(4'h0, 32'h2);
		pulse_run;
		repeat (8) @(negedge ref_clk_i);
		check(inhibit_o, 32'h0);
		pulse_run;
		wait_bit(0, 1'b1, 10);
		rd(4'h5, v); check(v[11:9], 32'h2);
		rd(4'h7, v); check(v[11:0] inside {[12'd3597:12'd3600]}, 32'h1);
		wr(4'h4, 32'h1);
		wait_bit(0, 1'b0, 5);
		// Time between starts
		wr(4'h0, 32'h0001_0000);
		pulse_run;
		wait_bit(1, 1'b1, 10);
		rd(4'h6, v); check(v[30:16] inside {[15'd57:15'd60]}, 32'h1);
		wait_bit(1, 1'b0, 700);
		// Backspin settings, illegal pole count ignored
		wr(4'h0, 32'h0);
		wr(4'h3, 32'h0064_0023);
		wr(4'h3, 32'h0064_0033);
		rd(4'h3, v); check(v, 32'h0064_0023);
		pulse_run;
		spin <= 1'b1;
		wait_bit(3, 1'b1, 10);
		repeat (2) @(negedge ref_clk_i);
		check(relay_o, 32'h1);
		repeat (30) @(posedge ref_clk_i);
		rd(4'h5, v); check(v[8:6], 32'h2);
		check(v[21:12] > 10'h0 && v[21:12] <= 10'd40, 32'h1);
		wait_bit(3, 1'b0, 600);
		@(posedge ref_clk_i);
		spin <= 1'b0;
		// Lost signal holds inhibit until prediction runs out
		pulse_run;
		spin <= 1'b1;
		wait_bit(3, 1'b1, 10);
		repeat (40) @(posedge ref_clk_i);
		lost <= 1'b1;
		repeat (5) @(posedge ref_clk_i);
		rd(4'h5, v); check({v[8:6], v[3]}, 32'h9);
		repeat (150) @(negedge ref_clk_i);
		check(inhibit_o.backspin, 32'h1);
		wait_bit(3, 1'b0, 11000);
		@(posedge ref_clk_i);
		{spin, lost} <= 2'b00;
		// Backspin disabled: stop raises nothing
		wr(4'h3, 32'h0);
		pulse_run;
		repeat (10) @(negedge ref_clk_i);
		check(inhibit_o, 32'h0);
		finish_test;
	end
endmodule
